// ---- hdl/sss_regs.svh ----
// register offsets, reset values and timing constants of the speed status block
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
`define SSS_ADDR_ZSP_THR   8'h00
`define SSS_ADDR_AT_THR    8'h04
`define SSS_ADDR_UV_SEL    8'h08
`define SSS_ADDR_OT_SEL    8'h0C
`define SSS_ADDR_PO_SEL    8'h10
`define SSS_ADDR_PO_TIME   8'h14
`define SSS_ADDR_ES_TORQUE 8'h18
`define SSS_ADDR_STATUS    8'h1C
`define SSS_ADDR_MASK      8'h20
`define SSS_ADDR_STATE     8'h24
`define SSS_RST_THR        16'h0032
`define SSS_RST_UV_SEL     1'h1
`define SSS_RST_OT_SEL     2'h0
`define SSS_RST_PO_SEL     4'h0
`define SSS_RST_PO_TIME    16'h0014
`define SSS_RST_ES_TORQUE  10'h0064
`define SSS_THR_MIN        16'h000A
`define SSS_THR_MAX        16'h4E20
`define SSS_HYST           16'h000A
`define SSS_OT_MAX         2'h2
`define SSS_PO_MAX         4'h9
`define SSS_PO_EST_BASE    4'h8
`define SSS_PO_HOLD_LO     4'h4
`define SSS_ST_UV          0
`define SSS_ST_OT          1
`define SSS_ST_PO          2
`define SSS_ST_W           3
`define SSS_CLK_PERIOD_NS  8
`define SSS_MS_NS          1000000
`define SSS_RESP_OKAY      2'h0
`define SSS_RESP_SLVERR    2'h2
`endif

// ---- hdl/sss_pkg.sv ----
// types shared by the speed status and stop sequence block
package sss_pkg;
	typedef enum logic [1:0] {STOP_RUN, STOP_DECEL, STOP_STALLED} sss_stop_e;
	typedef enum logic [1:0] {CAUSE_NONE, CAUSE_OT, CAUSE_PO} sss_cause_e;
	typedef enum logic [2:0] {ACT_NONE, ACT_DB, ACT_FREE, ACT_ZT, ACT_ESTOP} sss_act_e;
endpackage : sss_pkg

// ---- hdl/sss_sync.sv ----
// three-stage synchroniser for the pin inputs, change taken when stages two and three agree
`timescale 1ns/10ps
`include "sss_regs.svh"
module sss_sync (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [2:0] pinIn,
	output logic      [2:0] pinOut
);
	logic [2:0] stage1;
	logic [2:0] stage2;
	logic [2:0] stage3;
	logic [2:0] next_pinOut;

	// output only moves once the two late stages agree
	always_comb begin
		next_pinOut = pinOut;
		for (int i = 0; i < 3; i++) begin
			if (stage2[i] == stage3[i]) begin
				next_pinOut[i] = stage3[i];
			end
		end
	end

	// stage1 is read by stage2 alone
	always_ff @(posedge clk) begin
		if (srst) begin
			stage1 <= 3'h0;
			stage2 <= 3'h0;
			stage3 <= 3'h0;
			pinOut <= 3'h0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			pinOut <= next_pinOut;
		end
	end

	AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (srst)
		(stage2 == stage3) |=> (pinOut == $past(stage3)))
		else $error("synchroniser output missed agreed level");
endmodule : sss_sync

// ---- hdl/sss_hyst.sv ----
// speed threshold comparator with a hysteresis band on either side of the threshold
`timescale 1ns/10ps
`include "sss_regs.svh"
module sss_hyst (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] speedMag,
	input  wire logic [15:0] threshold,
	input  wire logic        activeBelow,
	output logic             detectOut
);
	logic        onCond;
	logic        offCond;
	logic        next_detectOut;
	logic [15:0] lowEdge;
	logic [15:0] highEdge;

	// threshold never drops under the band width, so no wrap below
	always_comb begin
		lowEdge        = threshold - `SSS_HYST;
		highEdge       = threshold + `SSS_HYST;
		onCond         = activeBelow ? (speedMag < lowEdge) : (speedMag > highEdge);
		offCond        = activeBelow ? (speedMag > highEdge) : (speedMag < lowEdge);
		next_detectOut = detectOut;
		if (onCond) begin
			next_detectOut = 1'b1;
		end else if (offCond) begin
			next_detectOut = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			detectOut <= 1'b0;
		end else begin
			detectOut <= next_detectOut;
		end
	end

	AST_HYST_ON: assert property (@(posedge clk) disable iff (srst)
		onCond |=> detectOut)
		else $error("detector did not switch on past the band");
	AST_HYST_OFF: assert property (@(posedge clk) disable iff (srst)
		offCond |=> !detectOut)
		else $error("detector did not switch off past the band");
	AST_HYST_HOLD: assert property (@(posedge clk) disable iff (srst)
		(!onCond && !offCond) |=> $stable(detectOut))
		else $error("detector moved inside the band");
endmodule : sss_hyst

// ---- hdl/sss_top.sv ----
// speed status outputs, stop sequence selection and register slave of the servo block
`timescale 1ns/10ps
`include "sss_regs.svh"
module sss_top import sss_pkg::*; #(
	parameter int MS_CYCLES = `SSS_MS_NS / `SSS_CLK_PERIOD_NS
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] motorSpeed,
	input  wire logic [15:0] commandSpeed,
	input  wire logic        cw_travel_inhibit_in,
	input  wire logic        ccw_travel_inhibit_in,
	input  wire logic        mainPowerOkIn,
	input  wire logic        powerUpStrobe,
	output logic             zero_speed_out,
	output logic             speed_coincidence_out,
	output logic             at_speed_out,
	output logic             torque_limited_out,
	output logic       [9:0] torqueLimitOut,
	output logic             dynamic_brake,
	output logic             freeRunOut,
	output logic             zeroTorqueCwOut,
	output logic             zeroTorqueCcwOut,
	output logic             emergencyStopOut,
	output logic             clearDeviationOut,
	output logic             main_undervoltage_error,
	output logic             irq,
	input  wire logic  [7:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic  [3:0] s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic       [1:0] s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic  [7:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic       [1:0] s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// register file and bus state
	logic [15:0] zero_speed_threshold, next_zero_speed_threshold;
	logic [15:0] at_speed_threshold, next_at_speed_threshold;
	logic        undervoltage_trip_select, next_undervoltage_trip_select;
	logic  [1:0] otPending, next_otPending;
	logic  [1:0] overtravel_sequence_select, next_overtravel_sequence_select;
	logic  [3:0] power_off_sequence_select, next_power_off_sequence_select;
	logic [15:0] power_off_detect_time, next_power_off_detect_time;
	logic  [9:0] emergency_stop_torque, next_emergency_stop_torque;
	logic [`SSS_ST_W-1:0] status, next_status, mask, next_mask, events;
	logic        awHeld, next_awHeld, wHeld, next_wHeld;
	logic  [7:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData, next_rdata;
	logic  [3:0] wStrb, next_wStrb;
	logic        next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
	logic  [1:0] next_bresp, next_rresp;
	logic        next_irq;
	// stop sequence and power-off timing state
	sss_stop_e   stopState, next_stopState;
	sss_cause_e  stopCause, next_stopCause;
	sss_act_e    act;
	logic [16:0] msCnt, next_msCnt;
	logic [15:0] offMs, next_offMs;
	logic        otPrev, next_otPrev, poPrev, next_poPrev;
	logic        next_uvError, poDetected, otAny, clearSel;
	logic        cwInh, ccwInh, powerOk;
	logic [15:0] speedMag, diffMag;

	// magnitude of a signed 16-bit speed, saturating at the top
	function automatic logic [15:0] magOf(input logic [16:0] v);
		logic [16:0] a;
		a = v[16] ? (17'h0_0000 - v) : v;
		return a[16] ? 16'hFFFF : a[15:0];
	endfunction : magOf

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// threshold writes are held inside the legal speed range
	function automatic logic [15:0] clampThr(input logic [15:0] v);
		if (v < `SSS_THR_MIN) begin
			return `SSS_THR_MIN;
		end
		return (v > `SSS_THR_MAX) ? `SSS_THR_MAX : v;
	endfunction : clampThr

	// power-off table: values 8 and 9 use emergency stop until the stall, bits pick free-run per phase
	function automatic sss_act_e poAction(input logic [3:0] sel, input logic stalled);
		if (!stalled && sel >= `SSS_PO_EST_BASE) begin
			return ACT_ESTOP;
		end
		if (sel >= `SSS_PO_EST_BASE) begin
			return sel[0] ? ACT_FREE : ACT_DB;
		end
		return (stalled ? sel[1] : sel[0]) ? ACT_FREE : ACT_DB;
	endfunction : poAction

	sss_sync u_sync (
		.clk    (clk),
		.srst   (srst),
		.pinIn  ({mainPowerOkIn, ccw_travel_inhibit_in, cw_travel_inhibit_in}),
		.pinOut ({powerOk, ccwInh, cwInh})
	);

	// signed speeds reduced to magnitudes so direction does not matter
	assign speedMag = magOf({motorSpeed[15], motorSpeed});
	assign diffMag  = magOf({commandSpeed[15], commandSpeed} - {motorSpeed[15], motorSpeed});

	sss_hyst u_zero (
		.clk         (clk),
		.srst        (srst),
		.speedMag    (speedMag),
		.threshold   (zero_speed_threshold),
		.activeBelow (1'b1),
		.detectOut   (zero_speed_out)
	);
	sss_hyst u_at_speed_out (
		.clk         (clk),
		.srst        (srst),
		.speedMag    (diffMag),
		.threshold   (zero_speed_threshold),
		.activeBelow (1'b1),
		.detectOut   (speed_coincidence_out)
	);
	sss_hyst u_at (
		.clk         (clk),
		.srst        (srst),
		.speedMag    (speedMag),
		.threshold   (at_speed_threshold),
		.activeBelow (1'b0),
		.detectOut   (at_speed_out)
	);

	// power-off timer in whole milliseconds; restarts each time main power returns
	always_comb begin
		next_msCnt = msCnt + 17'h0_0001;
		next_offMs = offMs;
		if (powerOk) begin
			next_msCnt = 17'h0_0000;
			next_offMs = 16'h0000;
		end else if (msCnt == 17'(MS_CYCLES - 1)) begin
			next_msCnt = 17'h0_0000;
			next_offMs = (offMs == 16'hFFFF) ? offMs : offMs + 16'h0001;
		end
		poDetected   = !powerOk && (offMs >= power_off_detect_time);
		otAny        = cwInh || ccwInh;
		next_uvError = main_undervoltage_error || (poDetected && undervoltage_trip_select);
		next_otPrev  = otAny;
		next_poPrev  = poDetected;
		events       = '0;
		events[`SSS_ST_UV] = next_uvError && !main_undervoltage_error;
		events[`SSS_ST_OT] = otAny && !otPrev;
		events[`SSS_ST_PO] = poDetected && !poPrev;
	end

	// stop phase: deceleration until the zero-speed detector reports a stall
	always_comb begin
		next_stopCause = poDetected ? CAUSE_PO : (otAny ? CAUSE_OT : CAUSE_NONE);
		next_stopState = stopState;
		if (next_stopCause == CAUSE_NONE) begin
			next_stopState = STOP_RUN;
		end else if (stopState == STOP_RUN || next_stopCause != stopCause) begin
			next_stopState = STOP_DECEL;
		end else if (zero_speed_out) begin
			next_stopState = STOP_STALLED;
		end
	end

	// action for the current phase; power-off outranks over-travel
	always_comb begin
		act      = ACT_NONE;
		clearSel = 1'b0;
		unique case (stopCause)
			CAUSE_NONE: begin
				act = ACT_NONE;
			end
			CAUSE_OT: begin
				clearSel = (overtravel_sequence_select == `SSS_OT_MAX);
				if (stopState == STOP_STALLED || overtravel_sequence_select == 2'h1) begin
					act = ACT_ZT;
				end else if (overtravel_sequence_select == `SSS_OT_MAX) begin
					act = ACT_ESTOP;
				end else begin
					act = ACT_DB;
				end
			end
			CAUSE_PO: begin
				act      = poAction(power_off_sequence_select, stopState == STOP_STALLED);
				clearSel = (power_off_sequence_select < `SSS_PO_HOLD_LO) ||
					(power_off_sequence_select >= `SSS_PO_EST_BASE);
			end
			default: begin
				act = ACT_NONE;
			end
		endcase
		if (stopState == STOP_RUN) begin
			act = ACT_NONE;
		end
	end

	// bus slave: address and data taken in either order, one write and one read at a time
	always_comb begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld  = wHeld;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp  = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp  = s_axi_rresp;
		next_rdata  = s_axi_rdata;
		next_zero_speed_threshold       = zero_speed_threshold;
		next_at_speed_threshold         = at_speed_threshold;
		next_undervoltage_trip_select   = undervoltage_trip_select;
		next_otPending                  = otPending;
		next_power_off_sequence_select  = power_off_sequence_select;
		next_power_off_detect_time      = power_off_detect_time;
		next_emergency_stop_torque      = emergency_stop_torque;
		next_mask                       = mask;
		next_status                     = status;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (awHeld && wHeld && !s_axi_bvalid) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = `SSS_RESP_OKAY;
			unique case (awAddr)
				`SSS_ADDR_ZSP_THR: next_zero_speed_threshold =
					clampThr(16'(merge(32'(zero_speed_threshold), wData, wStrb)));
				`SSS_ADDR_AT_THR: next_at_speed_threshold =
					clampThr(16'(merge(32'(at_speed_threshold), wData, wStrb)));
				`SSS_ADDR_UV_SEL: next_undervoltage_trip_select =
					1'(merge(32'(undervoltage_trip_select), wData, wStrb));
				`SSS_ADDR_OT_SEL: next_otPending = (2'(merge(32'(otPending), wData, wStrb)) >
					`SSS_OT_MAX) ? `SSS_OT_MAX : 2'(merge(32'(otPending), wData, wStrb));
				`SSS_ADDR_PO_SEL: next_power_off_sequence_select =
					(4'(merge(32'(power_off_sequence_select), wData, wStrb)) > `SSS_PO_MAX) ?
					`SSS_PO_MAX : 4'(merge(32'(power_off_sequence_select), wData, wStrb));
				`SSS_ADDR_PO_TIME: next_power_off_detect_time =
					16'(merge(32'(power_off_detect_time), wData, wStrb));
				`SSS_ADDR_ES_TORQUE: next_emergency_stop_torque =
					10'(merge(32'(emergency_stop_torque), wData, wStrb));
				`SSS_ADDR_MASK: next_mask =
					`SSS_ST_W'(merge(32'(mask), wData, wStrb));
				`SSS_ADDR_STATUS, `SSS_ADDR_STATE: next_bresp = `SSS_RESP_OKAY;
				default: next_bresp = `SSS_RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `SSS_RESP_OKAY;
			unique case (s_axi_araddr)
				`SSS_ADDR_ZSP_THR:   next_rdata = 32'(zero_speed_threshold);
				`SSS_ADDR_AT_THR:    next_rdata = 32'(at_speed_threshold);
				`SSS_ADDR_UV_SEL:    next_rdata = 32'(undervoltage_trip_select);
				`SSS_ADDR_OT_SEL:    next_rdata = 32'({overtravel_sequence_select, 2'h0, otPending});
				`SSS_ADDR_PO_SEL:    next_rdata = 32'(power_off_sequence_select);
				`SSS_ADDR_PO_TIME:   next_rdata = 32'(power_off_detect_time);
				`SSS_ADDR_ES_TORQUE: next_rdata = 32'(emergency_stop_torque);
				`SSS_ADDR_MASK:      next_rdata = 32'(mask);
				`SSS_ADDR_STATUS: begin
					next_rdata  = 32'(status);
					next_status = '0;
				end
				`SSS_ADDR_STATE: next_rdata = 32'({stopCause, stopState, main_undervoltage_error,
					powerOk, ccwInh, cwInh, at_speed_out, speed_coincidence_out, zero_speed_out});
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = `SSS_RESP_SLVERR;
				end
			endcase
		end
		// a new event in the clearing read cycle still lands
		next_status  = next_status | events;
		next_awready = !next_awHeld && !next_bvalid;
		next_wready  = !next_wHeld && !next_bvalid;
		next_arready = !next_rvalid;
		next_irq     = |(next_status & next_mask);
		// pending value copied only when control power comes up again
		next_overtravel_sequence_select = powerUpStrobe ? next_otPending :
			overtravel_sequence_select;
	end

	// all state registered here; outputs are direct flops
	always_ff @(posedge clk) begin
		if (srst) begin
			zero_speed_threshold       <= `SSS_RST_THR;
			at_speed_threshold         <= `SSS_RST_THR;
			undervoltage_trip_select   <= `SSS_RST_UV_SEL;
			otPending                  <= `SSS_RST_OT_SEL;
			overtravel_sequence_select <= `SSS_RST_OT_SEL;
			power_off_sequence_select  <= `SSS_RST_PO_SEL;
			power_off_detect_time      <= `SSS_RST_PO_TIME;
			emergency_stop_torque      <= `SSS_RST_ES_TORQUE;
			status <= '0;
			mask   <= '0;
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			wHeld  <= 1'b0;
			wData  <= 32'h0000_0000;
			wStrb  <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SSS_RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `SSS_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			irq        <= 1'b0;
			stopState  <= STOP_RUN;
			stopCause  <= CAUSE_NONE;
			msCnt      <= 17'h0_0000;
			offMs      <= 16'h0000;
			otPrev     <= 1'b0;
			poPrev     <= 1'b0;
			main_undervoltage_error <= 1'b0;
			dynamic_brake      <= 1'b0;
			freeRunOut         <= 1'b0;
			zeroTorqueCwOut    <= 1'b0;
			zeroTorqueCcwOut   <= 1'b0;
			emergencyStopOut   <= 1'b0;
			torque_limited_out <= 1'b0;
			torqueLimitOut     <= 10'h000;
			clearDeviationOut  <= 1'b0;
		end else begin
			zero_speed_threshold       <= next_zero_speed_threshold;
			at_speed_threshold         <= next_at_speed_threshold;
			undervoltage_trip_select   <= next_undervoltage_trip_select;
			otPending                  <= next_otPending;
			overtravel_sequence_select <= next_overtravel_sequence_select;
			power_off_sequence_select  <= next_power_off_sequence_select;
			power_off_detect_time      <= next_power_off_detect_time;
			emergency_stop_torque      <= next_emergency_stop_torque;
			status <= next_status;
			mask   <= next_mask;
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld  <= next_wHeld;
			wData  <= next_wData;
			wStrb  <= next_wStrb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_arready <= next_arready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
			irq        <= next_irq;
			stopState  <= next_stopState;
			stopCause  <= next_stopCause;
			msCnt      <= next_msCnt;
			offMs      <= next_offMs;
			otPrev     <= next_otPrev;
			poPrev     <= next_poPrev;
			main_undervoltage_error <= next_uvError;
			dynamic_brake      <= (act == ACT_DB);
			freeRunOut         <= (act == ACT_FREE);
			zeroTorqueCwOut    <= (act == ACT_ZT) && cwInh;
			zeroTorqueCcwOut   <= (act == ACT_ZT) && ccwInh;
			emergencyStopOut   <= (act == ACT_ESTOP);
			torque_limited_out <= (act == ACT_ESTOP);
			torqueLimitOut     <= (act == ACT_ESTOP) ? emergency_stop_torque : 10'h000;
			clearDeviationOut  <= clearSel && (stopState != STOP_RUN);
		end
	end

	AST_UV_SELECT: assert property (@(posedge clk) disable iff (srst)
		$rose(main_undervoltage_error) |-> $past(undervoltage_trip_select) && $past(poDetected))
		else $error("undervoltage error raised while not selected");
	AST_OT_BRAKE: assert property (@(posedge clk) disable iff (srst)
		(stopCause == CAUSE_OT && stopState == STOP_DECEL && overtravel_sequence_select == 2'h0)
		|=> dynamic_brake && !emergencyStopOut)
		else $error("over-travel value 0 did not brake");
	AST_OT_ESTOP_CLEAR: assert property (@(posedge clk) disable iff (srst)
		(stopCause == CAUSE_OT && stopState == STOP_DECEL && overtravel_sequence_select == 2'h2)
		|=> emergencyStopOut && clearDeviationOut)
		else $error("over-travel value 2 did not stop and clear");
	AST_PO_FREE_RUN: assert property (@(posedge clk) disable iff (srst)
		(stopCause == CAUSE_PO && stopState == STOP_STALLED && power_off_sequence_select == 4'h7)
		|=> freeRunOut && !clearDeviationOut)
		else $error("power-off value 7 wrong after stall");
	AST_PO_ZERO_ONE: assert property (@(posedge clk) disable iff (srst)
		(stopCause == CAUSE_PO && stopState == STOP_DECEL && power_off_sequence_select == 4'h1)
		|=> freeRunOut && clearDeviationOut)
		else $error("power-off value 1 wrong during deceleration");
	AST_OT_AT_POWERUP: assert property (@(posedge clk) disable iff (srst)
		!powerUpStrobe |=> $stable(overtravel_sequence_select))
		else $error("over-travel setting changed without power-up");
	AST_ESTOP_TORQUE: assert property (@(posedge clk) disable iff (srst)
		emergencyStopOut |-> torque_limited_out && (torqueLimitOut == $past(emergency_stop_torque)))
		else $error("emergency stop torque not limited");
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (srst)
		irq == |(status & mask))
		else $error("interrupt disagrees with status and mask");
	AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (srst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
endmodule : sss_top

// ---- testbench/sss_host_model.sv ----
// host i/o and motor model driving the speed and pin inputs of the block
`timescale 1ns/10ps
module sss_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] speedSet,
	input  wire logic [15:0] cmdSet,
	input  wire logic [2:0]  pinSet,
	output logic      [15:0] motorSpeed = 16'h0000,
	output logic      [15:0] commandSpeed = 16'h0000,
	output logic             cw_travel_inhibit_in = 1'b0,
	output logic             ccw_travel_inhibit_in = 1'b0,
	output logic             mainPowerOkIn = 1'b1
);
	// motor reaches the asked speed one edge later; pins are plain host levels
	always_ff @(posedge clk) begin
		motorSpeed <= speedSet;
		commandSpeed <= cmdSet;
		{mainPowerOkIn, ccw_travel_inhibit_in, cw_travel_inhibit_in} <= pinSet;
	end
endmodule : sss_host_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the speed status and stop sequence block
`timescale 1ns/10ps
`include "sss_regs.svh"
module tb_top;
	logic clk = 0, srst = 1, powerUpStrobe = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [15:0] speedSet = 0, cmdSet = 0, motorSpeed, commandSpeed;
	logic [2:0] pinSet = 3'b100;
	logic cw_travel_inhibit_in, ccw_travel_inhibit_in, mainPowerOkIn, zero_speed_out,
	 speed_coincidence_out, at_speed_out, torque_limited_out, dynamic_brake, freeRunOut,
	 zeroTorqueCwOut, zeroTorqueCcwOut, emergencyStopOut, clearDeviationOut, irq,
	 main_undervoltage_error, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
	 s_axi_rvalid;
	logic [9:0] torqueLimitOut;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int mismatches = 0, checked = 0, cycles = 0;
	sss_host_model sss_host_model_i (.*);
	// short millisecond keeps the power-off wait to about 80 cycles
	sss_top #(.MS_CYCLES(4)) sss_top_i (.*);
	always #4 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin mismatches++; tally_and_finish(); end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin mismatches++; $display("[ERR] %0t %s", $time, what); end
	endtask : chk
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		repeat (30) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin r = s_axi_bresp; break; end
		end
		s_axi_bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1; d = 'x;
		repeat (30) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin d = s_axi_rdata; r = s_axi_rresp; break; end
		end
		s_axi_rready <= 0;
	endtask : rd
	task automatic t_reset();
		rd(`SSS_ADDR_ZSP_THR); chk(d, 32'h0000_0032, "zero thr");
		rd(`SSS_ADDR_UV_SEL); chk(d, 32'h0000_0001, "uv sel");
		rd(8'h40); chk(r, `SSS_RESP_SLVERR, "unmapped");
		wr(8'h40, 32'h0000_0000); chk(r, `SSS_RESP_SLVERR, "unmapped write");
		$display("test reset done");
	endtask : t_reset
	// speed table: rows four and six sit inside the band and must hold
	task automatic t_speed();
		logic [15:0] sp[6] = '{16'd100, -16'sd100, -16'sd20, 16'd55, 16'd65, 16'd45};
		logic [15:0] cm[6] = '{16'd100, 16'd100, 16'd0, 16'd0, 16'd0, 16'd0};
		logic [2:0] ex[6] = '{3'b011, 3'b001, 3'b110, 3'b110, 3'b001, 3'b001};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk); speedSet <= sp[i]; cmdSet <= cm[i];
			repeat (3) @(posedge clk);
			chk({zero_speed_out, speed_coincidence_out, at_speed_out}, ex[i], "speed");
		end
		$display("test speed done");
	endtask : t_speed
	task automatic t_overtravel();
		// default setting: brake while still moving, deviation held
		@(posedge clk); pinSet <= 3'b110; repeat (10) @(posedge clk);
		chk({dynamic_brake, emergencyStopOut, clearDeviationOut}, 3'b100, "ot brake");
		@(posedge clk); pinSet <= 3'b100; repeat (10) @(posedge clk);
		wr(`SSS_ADDR_OT_SEL, 32'h0000_0002);
		rd(`SSS_ADDR_OT_SEL); chk(d, 32'h0000_0002, "ot pending only");
		@(posedge clk); powerUpStrobe <= 1; @(posedge clk); powerUpStrobe <= 0;
		rd(`SSS_ADDR_OT_SEL); chk(d, 32'h0000_0022, "ot active");
		@(posedge clk); pinSet <= 3'b101;
		repeat (10) @(posedge clk);
		chk({emergencyStopOut, torque_limited_out, clearDeviationOut}, 3'b111, "estop");
		chk(torqueLimitOut, `SSS_RST_ES_TORQUE, "estop torque");
		chk(irq, 1'b0, "masked irq");
		// stall: zero torque toward the inhibited cw side only, deviation still cleared
		@(posedge clk); speedSet <= 16'h0000; repeat (6) @(posedge clk);
		chk({zeroTorqueCwOut, zeroTorqueCcwOut, emergencyStopOut, clearDeviationOut}, 4'b1001,
			"ot stalled");
		@(posedge clk); pinSet <= 3'b100; speedSet <= 16'd100; repeat (10) @(posedge clk);
		$display("test overtravel done");
	endtask : t_overtravel
	task automatic t_poweroff();
		wr(`SSS_ADDR_MASK, 32'h0000_0005); wr(`SSS_ADDR_PO_SEL, 32'h0000_0001);
		@(posedge clk); pinSet <= 3'b000;
		repeat (300) begin @(posedge clk); if (freeRunOut === 1'b1) break; end
		repeat (2) @(posedge clk);
		chk({freeRunOut, clearDeviationOut, irq}, 3'b111, "po decel");
		chk(main_undervoltage_error, 1'b1, "uv error");
		@(posedge clk); speedSet <= 0; repeat (6) @(posedge clk);
		chk({dynamic_brake, clearDeviationOut}, 2'b11, "po stalled");
		rd(`SSS_ADDR_STATUS); chk(d, 32'h0000_0007, "status");
		rd(`SSS_ADDR_STATUS); chk(d, 32'h0000_0000, "status cleared");
		chk(irq, 1'b0, "irq cleared");
		$display("test poweroff done");
	endtask : t_poweroff
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(posedge clk); srst <= 0; repeat (6) @(posedge clk);
		t_reset(); t_speed(); t_overtravel(); t_poweroff(); tally_and_finish();
	end
endmodule : tb_top
